// ### rtpm_consts.svh
// register offsets, reset values and codes for the transmit packet and modulation block
`ifndef RTPM_CONSTS_SVH
`define RTPM_CONSTS_SVH
`define RTPM_OFS_ISTAT1     7'h03
`define RTPM_OFS_ISTAT2     7'h04
`define RTPM_OFS_OPCTRL     7'h07
`define RTPM_OFS_DIVCTRL    7'h08
`define RTPM_OFS_XTALTRIM   7'h09
`define RTPM_OFS_PIN1SEL    7'h0C
`define RTPM_OFS_PIN2SEL    7'h0D
`define RTPM_OFS_PKTCTRL    7'h30
`define RTPM_OFS_PREALEN    7'h34
`define RTPM_OFS_SYNCHI     7'h36
`define RTPM_OFS_SYNCLO     7'h37
`define RTPM_OFS_PKTLEN     7'h3E
`define RTPM_OFS_PUMPTEST   7'h57
`define RTPM_OFS_DIVTRIM    7'h59
`define RTPM_OFS_OSCTRIM    7'h5A
`define RTPM_OFS_RATEHI     7'h6E
`define RTPM_OFS_RATELO     7'h6F
`define RTPM_OFS_MODSRC     7'h71
`define RTPM_OFS_FIFO       7'h7F
`define RTPM_RST_PKTCTRL    8'h8D
`define RTPM_RST_MODSRC     8'h00
`define RTPM_RST_SYNCHI     8'h2D
`define RTPM_RST_SYNCLO     8'hD4
`define RTPM_RST_PREALEN    8'h08
`define RTPM_RST_RATE       16'h0100
`define RTPM_RST_XTALTRIM   8'h7F
`define RTPM_RST_PINSEL     8'h00
`define RTPM_BIT_TXON       3
`define RTPM_BIT_SWRST      7
`define RTPM_BIT_PHEN       3
`define RTPM_BIT_CRCEN      2
`define RTPM_BIT_DIVEN      7
`define RTPM_PKSENT_BIT     2
`define RTPM_PIN_TXSTATE    5'h12
`define RTPM_PIN_RXSTATE    5'h15
`define RTPM_PIN_ANT1       5'h17
`define RTPM_PIN_ANT2       5'h18
`define RTPM_PIN_MCUCLK     5'h00
`define RTPM_PIN_DIRECT     5'h03
`define RTPM_CRC_POLY       16'h8005
`define RTPM_CRC_INIT       16'h0000
`define RTPM_PN9_SEED       9'h1FF
`endif

// ### rtpm_pkg.sv
// types for the transmit packet and modulation block
package rtpm_pkg;
  typedef enum logic [1:0] {MT_CARRIER, MT_OOK, MT_FSK, MT_GFSK} rtpm_modtype_t;
  typedef enum logic [1:0] {SRC_DIRECT_PIN, SRC_DIRECT_SDI, SRC_FIFO, SRC_PN9} rtpm_source_t;
  typedef enum logic [2:0] {ST_IDLE, ST_PREAMBLE, ST_SYNC, ST_PAYLOAD, ST_CRC, ST_RAW}
    rtpm_phase_t;
endpackage

// ### rtpm_tx_fifo.sv
// 64-byte transmit byte store written by the host, read by the framer
`timescale 1ns/10ps
`include "rtpm_consts.svh"
module rtpm_tx_fifo
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clear,
  input  wire logic       push,
  input  wire logic [7:0] pushData,
  input  wire logic       pop,
  output logic      [7:0] headData,
  output logic            empty,
  output logic            full
);
  typedef struct packed
  {
    logic [5:0] wrPtr;
    logic [5:0] rdPtr;
    logic [6:0] count;
  } rtpm_fifo_state_t;
  rtpm_fifo_state_t st_reg;
  rtpm_fifo_state_t st_next;
  logic [7:0] mem [0:63];
  logic doPush;
  logic doPop;
  assign empty    = (st_reg.count == 7'h00);
  assign full     = (st_reg.count == 7'h40);
  assign headData = mem[st_reg.rdPtr];
  // a push into a full store is dropped rather than overwriting unsent data
  assign doPush   = push && !full;
  assign doPop    = pop && !empty;
  always_comb
  begin
    st_next = st_reg;
    if (doPush)
    begin
      st_next.wrPtr = st_reg.wrPtr + 6'h01;
    end
    if (doPop)
    begin
      st_next.rdPtr = st_reg.rdPtr + 6'h01;
    end
    if (doPush && !doPop)
    begin
      st_next.count = st_reg.count + 7'h01;
    end
    else if (doPop && !doPush)
    begin
      st_next.count = st_reg.count - 7'h01;
    end
    if (clear)
    begin
      st_next = '0;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (doPush)
    begin
      mem[st_reg.wrPtr] <= pushData;
    end
  end
endmodule

// ### rtpm_bit_source.sv
// bit-rate tick, PN9 generator and CRC-16 engine for the transmit path
`timescale 1ns/10ps
`include "rtpm_consts.svh"
module rtpm_bit_source
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [15:0] rateDiv,
  input  wire logic        running,
  input  wire logic        crcClear,
  input  wire logic        crcShift,
  input  wire logic        crcBit,
  output logic             bitTick,
  output logic             pnBit,
  output logic      [15:0] crcValue
);
  typedef struct packed
  {
    logic [15:0] count;
    logic        tick;
    logic [8:0]  lfsr;
    logic [15:0] crc;
  } rtpm_src_state_t;
  rtpm_src_state_t st_reg;
  rtpm_src_state_t st_next;
  logic fb;
  assign bitTick  = st_reg.tick;
  assign pnBit    = st_reg.lfsr[0];
  // next value, so the last payload bit is already folded in when the check byte loads
  assign crcValue = st_next.crc;
  assign fb       = crcBit ^ st_reg.crc[15];
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    // counter runs while sending or while a non-FIFO source is selected; preload one so the registered tick
    // still gives the first bit the same length as the rest
    if (!running)
    begin
      st_next.count = 16'h0001;
    end
    else if (st_reg.count >= rateDiv)
    begin
      st_next.count = 16'h0000;
      st_next.tick  = 1'b1;
    end
    else
    begin
      st_next.count = st_reg.count + 16'h0001;
    end
    if (st_reg.tick)
    begin
      st_next.lfsr = {st_reg.lfsr[0] ^ st_reg.lfsr[5], st_reg.lfsr[8:1]};
    end
    if (crcClear)
    begin
      st_next.crc = `RTPM_CRC_INIT;
    end
    else if (crcShift)
    begin
      st_next.crc = {st_reg.crc[14:0], 1'b0} ^ (fb ? `RTPM_CRC_POLY : 16'h0000);
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_reg      <= '0;
      st_reg.lfsr <= `RTPM_PN9_SEED;
      st_reg.crc  <= `RTPM_CRC_INIT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule

// ### rtpm_tx_core.sv
// Behaviour
// - sync bytes at 0x36 and 0x37 form pattern.
// - receiver filters packets by matching sync pattern.
// - 0x0D at 0x30 enables framer with CRC-16.
// - 64-byte FIFO serialized with internal bit timing.
// - internal PN9 generator can drive modulator.
// - 0x63 at 0x71 selects FIFO and GFSK.
// - modulation type zero gives unmodulated carrier.
// - modulation type two selects FSK.
// - FSK zero lowers, one raises carrier.
// - modulation type three selects GFSK.
// - GFSK shapes bits through Gaussian filter first.
// - modulation type one selects OOK.
// - OOK amplifier on for one, else off.
// - codes 0x17/0x18 route antenna switches to pins.
// - 0x80 at 0x08 enables antenna diversity.
// - codes 0x12/0x15 show transmit/receive state.
// - register 0x09 holds crystal load trim.
// - pin two can output the clock.
// - length register 0x3E sets payload byte count.
// - each write to 0x7F pushes one byte; a write while the 64-byte store is full is dropped.
// - 0x09 at 0x07 starts automatic transmission.
// - packet sent sets flag, interrupt until read.
`timescale 1ns/10ps
`include "rtpm_consts.svh"
module rtpm_tx_core
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [6:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       directPinData,
  input  wire logic       directSdiData,
  input  wire logic       rxStateIn,
  input  wire logic       antennaSelect,
  input  wire logic       mcuClockIn,
  output logic      [7:0] regRdata,
  output logic            irqOut_b,
  output logic            paEnable,
  output logic            freqUp,
  output logic            freqDown,
  output logic            gaussShape,
  output logic            txActive,
  output logic      [7:0] crystalTrim,
  output logic      [7:0] pumpTest,
  output logic      [7:0] dividerTrim,
  output logic      [7:0] oscTrim,
  output logic            pinOne,
  output logic            pinTwo
);
  typedef struct packed
  {
    logic [7:0]             opCtrl;
    logic [7:0]             divCtrl;
    logic [7:0]             xtal;
    logic [7:0]             pin1Sel;
    logic [7:0]             pin2Sel;
    logic [7:0]             pktCtrl;
    logic [7:0]             preaLen;
    logic [7:0]             syncHi;
    logic [7:0]             syncLo;
    logic [7:0]             pktLen;
    logic [7:0]             pump;
    logic [7:0]             divTrim;
    logic [7:0]             oscTrm;
    logic [15:0]            rate;
    logic [7:0]             modSrc;
    logic                   pkSent;
    rtpm_pkg::rtpm_phase_t  phase;
    logic [7:0]             shifter;
    logic [2:0]             bitIdx;
    logic [7:0]             byteCnt;
    logic                   curBit;
    logic [7:0]             rdata;
    logic                   irq_b;
    logic                   pa;
    logic                   up;
    logic                   down;
    logic                   gauss;
    logic                   active;
    logic                   p1;
    logic                   p2;
  } rtpm_core_state_t;
  rtpm_core_state_t st_reg;
  rtpm_core_state_t st_next;
  logic        tick;
  logic        pnBit;
  logic [15:0] crcValue;
  logic        fifoPush;
  logic        fifoPop;
  logic        fifoClear;
  logic [7:0]  fifoHead;
  logic        fifoEmpty;
  logic        fifoFull;
  logic        crcClear;
  logic        crcShift;
  logic        lastBit;
  logic        dataBit;
  logic        sending;
  rtpm_pkg::rtpm_modtype_t modType;
  rtpm_pkg::rtpm_source_t  modSource;
  // pin function decode, shared by both configurable pins
  function automatic logic pinFunc(input logic [4:0] code, input logic ant, input logic tx,
                                   input logic rx, input logic clk);
    case (code)
      `RTPM_PIN_ANT1:    pinFunc = !ant;
      `RTPM_PIN_ANT2:    pinFunc = ant;
      `RTPM_PIN_TXSTATE: pinFunc = tx;
      `RTPM_PIN_RXSTATE: pinFunc = rx;
      `RTPM_PIN_MCUCLK:  pinFunc = clk;
      default:           pinFunc = 1'b0;
    endcase
  endfunction
  assign modType   = rtpm_pkg::rtpm_modtype_t'(st_reg.modSrc[1:0]);
  assign modSource = rtpm_pkg::rtpm_source_t'(st_reg.modSrc[5:4]);
  assign fifoPush  = regWrite && (regAddr == `RTPM_OFS_FIFO);
  assign fifoClear = regWrite && (regAddr == `RTPM_OFS_OPCTRL) && regWdata[`RTPM_BIT_SWRST];
  assign lastBit   = tick && (st_reg.bitIdx == 3'h7);
  assign crcClear  = (st_reg.phase == rtpm_pkg::ST_IDLE);
  assign crcShift  = tick && (st_reg.phase == rtpm_pkg::ST_PAYLOAD)
                     && st_reg.pktCtrl[`RTPM_BIT_CRCEN];
  assign sending   = (st_reg.phase != rtpm_pkg::ST_IDLE);
  assign regRdata  = st_reg.rdata;
  assign irqOut_b  = st_reg.irq_b;
  assign paEnable  = st_reg.pa;
  assign freqUp    = st_reg.up;
  assign freqDown  = st_reg.down;
  assign gaussShape = st_reg.gauss;
  assign txActive  = st_reg.active;
  assign crystalTrim = st_reg.xtal;
  assign pumpTest  = st_reg.pump;
  assign dividerTrim = st_reg.divTrim;
  assign oscTrim   = st_reg.oscTrm;
  assign pinOne    = st_reg.p1;
  assign pinTwo    = st_reg.p2;
  // modulating bit: framed/raw shifter, PN9, or host-timed direct input
  always_comb
  begin
    case (modSource)
      rtpm_pkg::SRC_FIFO:       dataBit = st_reg.shifter[7];
      rtpm_pkg::SRC_PN9:        dataBit = pnBit;
      rtpm_pkg::SRC_DIRECT_SDI: dataBit = directSdiData;
      default:                  dataBit = directPinData;
    endcase
  end
  always_comb
  begin
    st_next = st_reg;
    // a byte leaves the store when it is loaded into the shifter
    fifoPop = 1'b0;
    // register writes
    if (regWrite)
    begin
      case (regAddr)
        `RTPM_OFS_OPCTRL:   st_next.opCtrl = regWdata;
        `RTPM_OFS_DIVCTRL:  st_next.divCtrl = regWdata;
        `RTPM_OFS_XTALTRIM: st_next.xtal = regWdata;
        `RTPM_OFS_PIN1SEL:  st_next.pin1Sel = regWdata;
        `RTPM_OFS_PIN2SEL:  st_next.pin2Sel = regWdata;
        `RTPM_OFS_PKTCTRL:  st_next.pktCtrl = regWdata;
        `RTPM_OFS_PREALEN:  st_next.preaLen = regWdata;
        `RTPM_OFS_SYNCHI:   st_next.syncHi = regWdata;
        `RTPM_OFS_SYNCLO:   st_next.syncLo = regWdata;
        `RTPM_OFS_PKTLEN:   st_next.pktLen = regWdata;
        `RTPM_OFS_PUMPTEST: st_next.pump = regWdata;
        `RTPM_OFS_DIVTRIM:  st_next.divTrim = regWdata;
        `RTPM_OFS_OSCTRIM:  st_next.oscTrm = regWdata;
        `RTPM_OFS_RATEHI:   st_next.rate[15:8] = regWdata;
        `RTPM_OFS_RATELO:   st_next.rate[7:0] = regWdata;
        `RTPM_OFS_MODSRC:   st_next.modSrc = regWdata;
        default:            st_next.opCtrl = st_next.opCtrl;
      endcase
    end
    // register reads; a read of ISTAT1 (0x03) clears the sent flag
    st_next.rdata = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        `RTPM_OFS_ISTAT1:  st_next.rdata = {5'h00, st_reg.pkSent, 2'h0};
        `RTPM_OFS_ISTAT2:  st_next.rdata = {7'h00, sending};
        `RTPM_OFS_OPCTRL:  st_next.rdata = st_reg.opCtrl;
        `RTPM_OFS_DIVCTRL: st_next.rdata = st_reg.divCtrl;
        `RTPM_OFS_XTALTRIM: st_next.rdata = st_reg.xtal;
        `RTPM_OFS_PIN1SEL: st_next.rdata = st_reg.pin1Sel;
        `RTPM_OFS_PIN2SEL: st_next.rdata = st_reg.pin2Sel;
        `RTPM_OFS_PKTCTRL: st_next.rdata = st_reg.pktCtrl;
        `RTPM_OFS_SYNCHI:  st_next.rdata = st_reg.syncHi;
        `RTPM_OFS_SYNCLO:  st_next.rdata = st_reg.syncLo;
        `RTPM_OFS_PKTLEN:  st_next.rdata = st_reg.pktLen;
        `RTPM_OFS_MODSRC:  st_next.rdata = st_reg.modSrc;
        `RTPM_OFS_PUMPTEST: st_next.rdata = st_reg.pump;
        `RTPM_OFS_DIVTRIM: st_next.rdata = st_reg.divTrim;
        `RTPM_OFS_OSCTRIM: st_next.rdata = st_reg.oscTrm;
        default:           st_next.rdata = 8'h00;
      endcase
      if (regAddr == `RTPM_OFS_ISTAT1)
      begin
        st_next.pkSent = 1'b0;
      end
    end
    // framer sequencing, one step per bit tick
    if (tick)
    begin
      st_next.bitIdx  = st_reg.bitIdx + 3'h1;
      st_next.shifter = {st_reg.shifter[6:0], 1'b0};
      if (lastBit)
      begin
        st_next.byteCnt = st_reg.byteCnt + 8'h01;
        case (st_reg.phase)
          rtpm_pkg::ST_PREAMBLE:
          begin
            st_next.shifter = 8'hAA;
            if (st_reg.byteCnt + 8'h01 >= st_reg.preaLen)
            begin
              st_next.phase   = rtpm_pkg::ST_SYNC;
              st_next.byteCnt = 8'h00;
              st_next.shifter = st_reg.syncHi;
            end
          end
          rtpm_pkg::ST_SYNC:
          begin
            st_next.shifter = st_reg.syncLo;
            if (st_reg.byteCnt == 8'h01)
            begin
              st_next.phase   = rtpm_pkg::ST_PAYLOAD;
              st_next.byteCnt = 8'h00;
              st_next.shifter = fifoHead;
              fifoPop         = 1'b1;
            end
          end
          rtpm_pkg::ST_PAYLOAD:
          begin
            if (st_reg.byteCnt + 8'h01 < st_reg.pktLen)
            begin
              st_next.shifter = fifoHead;
              fifoPop         = 1'b1;
            end
            else
            begin
              st_next.byteCnt = 8'h00;
              st_next.phase   = st_reg.pktCtrl[`RTPM_BIT_CRCEN] ? rtpm_pkg::ST_CRC
                                : rtpm_pkg::ST_IDLE;
              st_next.shifter = crcValue[15:8];
            end
          end
          rtpm_pkg::ST_CRC:
          begin
            st_next.shifter = crcValue[7:0];
            if (st_reg.byteCnt == 8'h01)
            begin
              st_next.phase = rtpm_pkg::ST_IDLE;
            end
          end
          rtpm_pkg::ST_RAW:
          begin
            if (fifoEmpty || (st_reg.byteCnt + 8'h01 >= st_reg.pktLen))
            begin
              st_next.phase = rtpm_pkg::ST_IDLE;
            end
            else
            begin
              st_next.shifter = fifoHead;
              fifoPop         = 1'b1;
            end
          end
          default: st_next.phase = rtpm_pkg::ST_IDLE;
        endcase
        if (st_next.phase == rtpm_pkg::ST_IDLE)
        begin
          st_next.pkSent = 1'b1;
          st_next.opCtrl[`RTPM_BIT_TXON] = 1'b0;
        end
      end
    end
    // start: transmit bit set while idle
    if (!sending && st_reg.opCtrl[`RTPM_BIT_TXON])
    begin
      st_next.bitIdx  = 3'h0;
      st_next.byteCnt = 8'h00;
      if (st_reg.pktCtrl[`RTPM_BIT_PHEN])
      begin
        st_next.phase   = rtpm_pkg::ST_PREAMBLE;
        st_next.shifter = 8'hAA;
      end
      else
      begin
        st_next.phase   = rtpm_pkg::ST_RAW;
        st_next.shifter = fifoHead;
        fifoPop         = 1'b1;
      end
    end
    // modulator outputs; carrier is held only while transmitting
    st_next.active = sending;
    st_next.gauss  = sending && (modType == rtpm_pkg::MT_GFSK);
    case (modType)
      rtpm_pkg::MT_CARRIER:
      begin
        st_next.pa   = sending;
        st_next.up   = 1'b0;
        st_next.down = 1'b0;
      end
      rtpm_pkg::MT_OOK:
      begin
        st_next.pa   = sending && dataBit;
        st_next.up   = 1'b0;
        st_next.down = 1'b0;
      end
      default:
      begin
        st_next.pa   = sending;
        st_next.up   = sending && dataBit;
        st_next.down = sending && !dataBit;
      end
    endcase
    st_next.irq_b = !st_next.pkSent;
    st_next.p1 = pinFunc(st_reg.pin1Sel[4:0], antennaSelect && st_reg.divCtrl[`RTPM_BIT_DIVEN],
                         sending, rxStateIn, 1'b0);
    st_next.p2 = pinFunc(st_reg.pin2Sel[4:0], antennaSelect && st_reg.divCtrl[`RTPM_BIT_DIVEN],
                         sending, rxStateIn, mcuClockIn);
    if (fifoClear)
    begin
      st_next.phase = rtpm_pkg::ST_IDLE;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_reg         <= '0;
      st_reg.pktCtrl <= `RTPM_RST_PKTCTRL;
      st_reg.modSrc  <= `RTPM_RST_MODSRC;
      st_reg.syncHi  <= `RTPM_RST_SYNCHI;
      st_reg.syncLo  <= `RTPM_RST_SYNCLO;
      st_reg.preaLen <= `RTPM_RST_PREALEN;
      st_reg.rate    <= `RTPM_RST_RATE;
      st_reg.xtal    <= `RTPM_RST_XTALTRIM;
      st_reg.phase   <= rtpm_pkg::ST_IDLE;
      st_reg.irq_b   <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  rtpm_tx_fifo u_fifo
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clear    (fifoClear),
    .push     (fifoPush),
    .pushData (regWdata),
    .pop      (fifoPop),
    .headData (fifoHead),
    .empty    (fifoEmpty),
    .full     (fifoFull)
  );
  rtpm_bit_source u_src
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .rateDiv  (st_reg.rate),
    .running  (sending || (modSource != rtpm_pkg::SRC_FIFO)),
    .crcClear (crcClear),
    .crcShift (crcShift),
    .crcBit   (st_reg.shifter[7]),
    .bitTick  (tick),
    .pnBit    (pnBit),
    .crcValue (crcValue)
  );
endmodule

// ### rtpm_tx_core_properties.sv
// port-level assertion checker for the transmit core
`timescale 1ns/10ps
module rtpm_tx_core_chk
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       irqOut_b,
  input wire logic       freqUp,
  input wire logic       freqDown,
  input wire logic       txActive,
  input wire logic [7:0] crystalTrim
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_trim_rst;
    $rose(rst_b) |-> crystalTrim == 8'h7F;
  endproperty
  a_trim_rst: assert property (p_trim_rst) else $error("trim reset value wrong");
  property p_trim_wr;
    regWrite && regAddr == 7'h09 |=> crystalTrim == $past(regWdata);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
  property p_trim_rd;
    regRead && !regWrite && regAddr == 7'h09 |=> regRdata == crystalTrim;
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim readback wrong");
  property p_freq_excl;
    !(freqUp && freqDown);
  endproperty
  a_freq_excl: assert property (p_freq_excl) else $error("both shifts at once");
  // registered shift lines and the active flag are set from sending in the same cycle
  property p_freq_tx;
    freqUp || freqDown |-> txActive || $past(txActive);
  endproperty
  a_freq_tx: assert property (p_freq_tx) else $error("shift outside transmit");
  property p_tx_start;
    regWrite && regAddr == 7'h07 && regWdata == 8'h09 && !txActive |-> ##[1:4] txActive;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit did not start");
  property p_irq_set;
    $fell(irqOut_b) |=> !txActive;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("sent flag during transmit");
  property p_irq_hold;
    !irqOut_b && !regRead && !regWrite |=> !irqOut_b;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unread");
  property p_irq_clr;
    !irqOut_b && regRead && regAddr == 7'h03 |-> ##[1:2] irqOut_b;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not released");
endmodule

bind rtpm_tx_core rtpm_tx_core_chk chk (.*);

// ### rtpm_host_model.sv
// host controller model driving register accesses
`timescale 1ns/10ps
module rtpm_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            directPinData,
  output logic            directSdiData
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
    directPinData = 1'b0; // no direct frames sent, lines parked
    directSdiData = 1'b0;
  end
  // strobe held for one taken edge; data inverted after so stale values never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule

// ### testbench.sv
// self-checking testbench for the transmit core
`timescale 1ns/10ps
`include "rtpm_consts.svh"
module testbench;
  typedef struct packed {logic [6:0] a; logic [7:0] d;} rtpm_row_t;
  logic       clk_sys, rst_b, regWrite, regRead, directPinData, directSdiData;
  logic       rxStateIn, antennaSelect, mcuClockIn, irqOut_b, paEnable, freqUp;
  logic       freqDown, gaussShape, txActive, pinOne, pinTwo;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, crystalTrim, pumpTest, dividerTrim, oscTrim, rv;
  int         fails, cmp_count, ups, dns, pas, gss, pns, tcs;
  rtpm_row_t  rows [12] = '{'{7'h08, 8'h80}, '{7'h09, 8'hD7}, '{7'h0C, 8'h17},
    '{7'h0D, 8'h18}, '{7'h30, 8'h0D}, '{7'h36, 8'h2D}, '{7'h37, 8'hD4}, '{7'h57, 8'h01},
    '{7'h59, 8'h40}, '{7'h5A, 8'h7F}, '{7'h71, 8'h63}, '{7'h3E, 8'h08}};
  rtpm_tx_core dut (.*);
  rtpm_host_model host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask
  // fixed window longer than the packet; counts cycles of each modulator line
  task automatic run_tx(input int lim);
    ups = 0; dns = 0; pas = 0; gss = 0; pns = 0; tcs = 0;
    host.wr(7'h07, 8'h09);
    repeat (lim)
    begin
      @(posedge clk_sys);
      #1;
      ups += (freqUp === 1'b1);
      dns += (freqDown === 1'b1);
      pas += (paEnable === 1'b1);
      gss += (gaussShape === 1'b1);
      pns += (pinOne === 1'b1);
      tcs += (txActive === 1'b1);
    end
    chk(txActive, 1'b0);
    chk(irqOut_b, 1'b0);
    chk(pns, tcs);
    host.rd(7'h03, rv);
    chk(rv[2], 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irqOut_b, 1'b1);
  endtask
  initial
  begin
    #(10000 * 5);
    fails++;
    end_of_test();
  end
  initial
  begin
    rst_b = 1'b0;
    rxStateIn = 1'b0;
    antennaSelect = 1'b0;
    mcuClockIn = 1'b0;
    do_reset();
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, rv);
      chk(rv, rows[i].d);
    end
    chk({crystalTrim, pumpTest, dividerTrim, oscTrim}, 32'hD701407F);
    do_reset();
    @(posedge clk_sys);
    #1;
    chk({irqOut_b, crystalTrim, regRdata}, 17'h17F00);
    host.rd(7'h30, rv);
    chk(rv, `RTPM_RST_PKTCTRL);
    host.rd(7'h01, rv);
    chk(rv, 8'h00);
    host.wr(7'h0C, 8'h15);
    rxStateIn <= 1'b1;
    host.wr(7'h0D, 8'h00);
    mcuClockIn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({pinOne, pinTwo}, 2'b11);
    mcuClockIn <= 1'b0;
    host.wr(7'h0C, 8'h12);
    #1;
    chk(pinTwo, 1'b0);
    host.wr(7'h6E, 8'h00);
    host.wr(7'h6F, 8'h02);
    host.wr(7'h30, 8'h00); // raw packet built here
    host.wr(7'h3E, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      host.wr(7'h71, 8'h20 | 8'(m));
      host.wr(7'h7F, 8'hC0);
      run_tx(60);
      chk(ups, m >= 2 ? 6 : 0);
      chk(dns, m >= 2 ? 18 : 0);
      if (m == 1)
        chk(pas, 6);
      chk(gss > 0, m == 3);
    end
    host.wr(7'h30, 8'h0D);
    host.wr(7'h34, 8'h01);
    host.wr(7'h7F, 8'h00);
    run_tx(250);
    chk({ups, dns}, {32'd36, 32'd108});
    host.wr(7'h30, 8'h00);
    host.wr(7'h3E, 8'h41);
    repeat (64) host.wr(7'h7F, 8'hFF);
    host.wr(7'h7F, 8'h00);
    run_tx(1700);
    chk({ups, dns}, {32'd1536, 32'd0});
    end_of_test();
  end
endmodule
